// ==== src/dac_pkg.sv ====
// Package for the display audio codec verb decoder: verb codes, field positions, reset values.
// Assumes a codec link that delivers one 12-bit verb with an 8-bit payload per request.
package dac_pkg;

  // ==========================================================================
  // Verb codes (12-bit verb identifiers).
  localparam logic [11:0] DAC_V_GET_PARAM = 12'hF00;
  localparam logic [11:0] DAC_V_PIN_SENSE = 12'hF09;
  localparam logic [11:0] DAC_V_SET_CFG0 = 12'h71C;
  localparam logic [11:0] DAC_V_SET_CFG1 = 12'h71D;
  localparam logic [11:0] DAC_V_SET_CFG2 = 12'h71E;
  localparam logic [11:0] DAC_V_SET_CFG3 = 12'h71F;
  localparam logic [11:0] DAC_V_GET_CFG = 12'hF1C;
  localparam logic [11:0] DAC_V_GET_MBOX = 12'hF1E;
  localparam logic [11:0] DAC_V_IF_SIZE = 12'hF2E;
  localparam logic [11:0] DAC_V_SET_IFIDX = 12'h730;
  localparam logic [11:0] DAC_V_GET_IFIDX = 12'hF30;
  localparam logic [11:0] DAC_V_SET_IFDATA = 12'h731;
  localparam logic [11:0] DAC_V_GET_IFDATA = 12'hF31;
  localparam logic [11:0] DAC_V_SET_IFTX = 12'h732;
  localparam logic [11:0] DAC_V_GET_IFTX = 12'hF32;
  localparam logic [11:0] DAC_V_SET_PROT = 12'h733;
  localparam logic [11:0] DAC_V_SET_CCMAP = 12'h734;
  localparam logic [11:0] DAC_V_GET_CCMAP = 12'hF34;
  localparam logic [11:0] DAC_V_SET_DEVSEL = 12'h735;
  localparam logic [11:0] DAC_V_GET_DEVSEL = 12'hF35;
  localparam logic [11:0] DAC_V_GET_DDL = 12'hF36;
  localparam logic [11:0] DAC_V_SET_SSID = 12'h73C;
  localparam logic [11:0] DAC_V_GET_SSID = 12'hF3C;
  localparam logic [11:0] DAC_V_SET_UNSOL = 12'h708;
  localparam logic [11:0] DAC_V_GET_UNSOL = 12'hF08;
  localparam logic [11:0] DAC_V_SET_VEND = 12'h781;
  localparam logic [11:0] DAC_V_GET_VEND = 12'hF81;
  localparam logic [11:0] DAC_V_TRIG = 12'h782;
  localparam logic [11:0] DAC_V_GET_CGTC = 12'hF83;
  localparam logic [11:0] DAC_V_CAPTURED_WALL_CLOCK = 12'hF84;
  localparam logic [11:0] DAC_V_GET_OFS = 12'hF85;
  localparam logic [11:0] DAC_V_SET_OFS0 = 12'h785;
  localparam logic [11:0] DAC_V_SET_OFS3 = 12'h788;
  localparam logic [11:0] DAC_V_SET_GDI = 12'h789;
  localparam logic [11:0] DAC_V_GET_GDI = 12'hF89;

  // ==========================================================================
  // Parameters, constants and field positions.
  localparam logic [7:0] DAC_PARAM_AWC = 8'h09;
  localparam logic [3:0] DAC_VENDOR_WTYPE = 4'hF;
  localparam int DAC_WTYPE_LSB = 20;
  localparam logic [7:0] DAC_IF_SIZE_GP = 8'h1E;
  localparam logic [7:0] DAC_IF_SIZE_SINK = 8'h53;
  localparam logic [7:0] DAC_IF_SINK_IDX = 8'h08;
  localparam logic [2:0] DAC_IF_SLOT_MAX = 3'h4;
  localparam int DAC_IF_BYTES = 32;
  localparam int DAC_IF_SLOTS = 5;
  localparam int DAC_PS_PRES = 31;
  localparam int DAC_PS_VALID = 30;
  localparam int DAC_PS_IDLE = 29;
  localparam int DAC_MST_EN_BIT = 1;
  localparam int DAC_NPIPE = 4;
  localparam logic [31:0] DAC_CFG_RESET = 32'h0000_0000;
  localparam logic [7:0] DAC_BYTE_RESET = 8'h00;
  localparam logic [31:0] DAC_WORD_RESET = 32'h0000_0000;

  // ==========================================================================
  // Carriers and enumerations.
  typedef enum logic [1:0] {
    DAC_LINK_JACK = 2'b00,
    DAC_LINK_NONE = 2'b01,
    DAC_LINK_FIXED = 2'b10,
    DAC_LINK_BOTH = 2'b11
  } dac_link_e;

  typedef enum logic [1:0] {
    DAC_TX_OFF = 2'b00,
    DAC_TX_RSVD = 2'b01,
    DAC_TX_ONCE = 2'b10,
    DAC_TX_BEST = 2'b11
  } dac_tx_e;

  typedef struct packed {
    logic valid;
    logic [11:0] verb;
    logic [7:0] payload;
  } dac_cmd_s;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } dac_rsp_s;

  typedef struct packed {
    logic sink_idle;
    logic sink_info_valid;
    logic presence_sensed;
  } dac_pipe_s;

endpackage : dac_pkg

// ==== src/dac_verbs.sv ====
// Verb decoder for the display audio codec's pin-complex and vendor widgets.
// Assumes one verb per request on cmd, answered on rsp one cycle later; pipe status, transcoder
// mode and timers are synchronous inputs.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Multistream indexing only when transcoder is multistream and vendor bit 1 is set.
// - Single-stream pin sense reports the pin's own pipe, payload ignored.
// - Pin sense answer: presence bit 31, sink info valid 30, idle 29.
// - Four byte verbs load configuration default; read returns all four bytes.
// - Top config bits 7:6 encode external link kind: jack, none, fixed, both.
// - Infoframe size is 1Eh for indexes 0-3, 53h for the sink-info index.
// - Infoframe index holds slot in 7:5 and byte pointer in 4:0, reset zero.
// - Infoframe data verb writes or reads the byte at slot and pointer.
// - Transmit control of indexed infoframe in bits 7:6; reset disables.
// - Protection control stores bits 7:3 as unsolicited subtag.
// - Channel map holds converter channel 7:4 and slot 3:0, reset zero.
// - Device select read: entry index 5:0, sink device id 11:6, rest zero.
// - Device list read packs four entries as nibbles: presence, valid, idle.
// - Stream id verb holds tag in 7:3 and identifier index in 2:0.
// - Vendor widget capability reports type Fh in bits 23:20, rest zero.
// - Mailbox set stores a byte; mailbox read returns it in bits 23:16.
// - Vendor unsolicited control: bit 7 allows mailbox events, 5:0 the label.
// - Trigger verb on the vendor widget captures global time code and wall clock together.
// - Separate reads return captured wall clock and time code, reset zero.
// - Four byte verbs load the time-code offset; read returns 32 bits.
// - Time-code device index in bits 5:0 selects a pipe, zero is pipe A.
module dac_verbs #(
  parameter int PIPE_OF_PIN = 0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire dac_pkg::dac_cmd_s cmd,
  input wire logic vendor_node,
  input wire logic transcoder_port_mode,
  input wire dac_pkg::dac_pipe_s [3:0] pipe_status,
  input wire logic [31:0] global_time_code,
  input wire logic [31:0] wall_clock,
  output dac_pkg::dac_rsp_s rsp,
  output logic unsol_event,
  output logic [5:0] unsol_label,
  output logic [4:0] unsol_subtag,
  output logic [1:0] infoframe_send_policy,
  output logic [2:0] infoframe_slot,
  output logic [7:0] converter_channel_map,
  output logic [7:0] stream_id_tag,
  output logic [31:0] time_code_offset,
  output logic [5:0] time_code_device_index,
  output logic multistream_mode
);
  import dac_pkg::*;

  // ==========================================================================
  // Storage.
  logic [31:0] pin_config_default;
  logic [7:0] driver_mailbox;
  logic [4:0] byte_pointer;
  logic [1:0] send_policy [DAC_IF_SLOTS];
  logic [7:0] if_mem [DAC_IF_SLOTS][DAC_IF_BYTES];
  logic [7:0] device_select;
  logic [7:0] vendor_verb;
  logic [7:0] unsol_ctrl;
  logic [31:0] captured_wall_clock;
  logic [31:0] captured_time_code;
  dac_rsp_s next_rsp;

  // ==========================================================================
  // Decode.
  wire logic [11:0] verb = cmd.verb;
  wire logic [7:0] pl = cmd.payload;
  wire logic go = cmd.valid;
  wire logic mst = transcoder_port_mode & vendor_verb[DAC_MST_EN_BIT];
  wire logic [5:0] sel_pipe = mst ? pl[5:0] : 6'(PIPE_OF_PIN);
  wire logic sel_ok = sel_pipe < 6'(DAC_NPIPE);
  wire dac_pipe_s sel_st = sel_ok ? pipe_status[sel_pipe[1:0]] : '0;
  wire logic [31:0] sense_word = {sel_st.presence_sensed, sel_st.sink_info_valid,
                                  sel_st.sink_idle, 29'h0000_0000};
  wire logic slot_ok = infoframe_slot <= DAC_IF_SLOT_MAX;
  wire logic [7:0] if_byte = slot_ok ? if_mem[infoframe_slot][byte_pointer] : 8'h00;
  wire logic [1:0] cur_policy = slot_ok ? send_policy[infoframe_slot] : 2'b00;
  wire logic is_ofs = verb >= DAC_V_SET_OFS0 && verb <= DAC_V_SET_OFS3;
  wire logic [1:0] ofs_lane = 2'(verb - DAC_V_SET_OFS0);
  wire logic is_cfg = verb >= DAC_V_SET_CFG0 && verb <= DAC_V_SET_CFG3;
  wire logic [1:0] cfg_lane = 2'(verb - DAC_V_SET_CFG0);
  wire logic mbox_set = vendor_node && verb == DAC_V_SET_CFG2;
  wire logic if_access = !vendor_node && (verb == DAC_V_SET_IFDATA || verb == DAC_V_GET_IFDATA);
  logic [15:0] ddl_word;

  genvar g;
  generate
    for (g = 0; g < DAC_NPIPE; g++) begin : g_ddl
      assign ddl_word[4*g +: 4] = {1'b0, pipe_status[g].sink_idle,
                                   pipe_status[g].sink_info_valid,
                                   pipe_status[g].presence_sensed};
    end
  endgenerate

  // ==========================================================================
  // Response multiplexer.
  always_comb begin
    next_rsp.valid = go;
    next_rsp.data = 32'h0000_0000;
    if (vendor_node) begin
      case (verb)
        DAC_V_GET_PARAM: begin
          if (pl == DAC_PARAM_AWC) begin
            next_rsp.data[DAC_WTYPE_LSB +: 4] = DAC_VENDOR_WTYPE;
          end
        end
        DAC_V_GET_MBOX: next_rsp.data = {pin_config_default[31:24], driver_mailbox,
                                         pin_config_default[15:0]};
        DAC_V_GET_UNSOL: next_rsp.data = {24'h00_0000, unsol_ctrl};
        DAC_V_GET_VEND: next_rsp.data = {24'h00_0000, vendor_verb};
        DAC_V_GET_CGTC: next_rsp.data = captured_time_code;
        DAC_V_CAPTURED_WALL_CLOCK: next_rsp.data = captured_wall_clock;
        DAC_V_GET_OFS: next_rsp.data = time_code_offset;
        DAC_V_GET_GDI: next_rsp.data = {26'h000_0000, time_code_device_index};
        default: next_rsp.data = 32'h0000_0000;
      endcase
    end else begin
      case (verb)
        DAC_V_PIN_SENSE: next_rsp.data = sense_word;
        DAC_V_GET_CFG: next_rsp.data = pin_config_default;
        DAC_V_IF_SIZE: begin
          if (pl < 8'h04) begin
            next_rsp.data = {24'h00_0000, DAC_IF_SIZE_GP};
          end else if (pl == DAC_IF_SINK_IDX) begin
            next_rsp.data = {24'h00_0000, DAC_IF_SIZE_SINK};
          end
        end
        DAC_V_GET_IFIDX: next_rsp.data = {24'h00_0000, infoframe_slot, byte_pointer};
        DAC_V_GET_IFDATA: next_rsp.data = {24'h00_0000, if_byte};
        DAC_V_GET_IFTX: next_rsp.data = {24'h00_0000, cur_policy, 6'h00};
        DAC_V_GET_CCMAP: next_rsp.data = {24'h00_0000, converter_channel_map};
        DAC_V_GET_DEVSEL: next_rsp.data = {20'h0_0000, 4'h0, device_select[3:2],
                                           device_select[5:0]} & 32'h0000_0FFF;
        DAC_V_GET_DDL: next_rsp.data = {16'h0000, ddl_word};
        DAC_V_GET_SSID: next_rsp.data = {24'h00_0000, stream_id_tag};
        default: next_rsp.data = 32'h0000_0000;
      endcase
      if (verb == DAC_V_GET_DEVSEL) begin
        next_rsp.data = {20'h0_0000, sel_pipe_id(device_select[5:0]),
                         device_select[5:0]};
      end
    end
  end

  function automatic logic [5:0] sel_pipe_id(input logic [5:0] entry);
    sel_pipe_id = mst ? entry : 6'(PIPE_OF_PIN);
  endfunction : sel_pipe_id

  // ==========================================================================
  // Set verbs on the pin widget.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_config_default <= DAC_CFG_RESET;
    end else if (go && is_cfg && !vendor_node) begin
      pin_config_default[8*cfg_lane +: 8] <= pl;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      infoframe_slot <= 3'h0;
      byte_pointer <= 5'h00;
    end else if (go && !vendor_node && verb == DAC_V_SET_IFIDX) begin
      infoframe_slot <= pl[7:5];
      byte_pointer <= pl[4:0];
    end else if (go && if_access) begin
      byte_pointer <= byte_pointer + 5'h01;
    end
  end

  generate
    for (g = 0; g < DAC_IF_SLOTS; g++) begin : g_slot
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          send_policy[g] <= 2'b00;
        end else if (go && !vendor_node && verb == DAC_V_SET_IFTX && infoframe_slot == g) begin
          send_policy[g] <= pl[7:6];
        end
      end
    end
  endgenerate

  // Packet buffers carry no reset; they are memory contents loaded by software.
  always_ff @(posedge clk_sys) begin
    if (go && !vendor_node && verb == DAC_V_SET_IFDATA && slot_ok) begin
      if_mem[infoframe_slot][byte_pointer] <= pl;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      unsol_subtag <= 5'h00;
      converter_channel_map <= DAC_BYTE_RESET;
      device_select <= DAC_BYTE_RESET;
      stream_id_tag <= DAC_BYTE_RESET;
    end else if (go && !vendor_node) begin
      if (verb == DAC_V_SET_PROT) begin
        unsol_subtag <= pl[7:3];
      end
      if (verb == DAC_V_SET_CCMAP) begin
        converter_channel_map <= pl;
      end
      if (verb == DAC_V_SET_DEVSEL) begin
        device_select <= {2'b00, pl[5:0]};
      end
      if (verb == DAC_V_SET_SSID) begin
        stream_id_tag <= pl;
      end
    end
  end

  // ==========================================================================
  // Set verbs on the vendor widget.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      driver_mailbox <= DAC_BYTE_RESET;
      vendor_verb <= DAC_BYTE_RESET;
      unsol_ctrl <= DAC_BYTE_RESET;
      time_code_offset <= DAC_WORD_RESET;
      time_code_device_index <= 6'h00;
    end else if (go && vendor_node) begin
      if (mbox_set) begin
        driver_mailbox <= pl;
      end
      if (verb == DAC_V_SET_VEND) begin
        vendor_verb <= pl;
      end
      if (verb == DAC_V_SET_UNSOL) begin
        unsol_ctrl <= {pl[7], 1'b0, pl[5:0]};
      end
      if (is_ofs) begin
        time_code_offset[8*ofs_lane +: 8] <= pl;
      end
      if (verb == DAC_V_SET_GDI) begin
        time_code_device_index <= pl[5:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      captured_wall_clock <= DAC_WORD_RESET;
      captured_time_code <= DAC_WORD_RESET;
    end else if (go && vendor_node && verb == DAC_V_TRIG) begin
      captured_wall_clock <= wall_clock;
      captured_time_code <= global_time_code;
    end
  end

  // ==========================================================================
  // Outputs.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rsp <= '0;
      unsol_event <= 1'b0;
      unsol_label <= 6'h00;
      infoframe_send_policy <= 2'b00;
      multistream_mode <= 1'b0;
    end else begin
      rsp <= next_rsp;
      unsol_event <= go && mbox_set && unsol_ctrl[7];
      unsol_label <= unsol_ctrl[5:0];
      infoframe_send_policy <= cur_policy;
      multistream_mode <= mst;
    end
  end

endmodule : dac_verbs

`default_nettype wire

// ==== testbench/dac_verbs_assertions.sv ====
// Port relations of the verb decoder.
// Bound into every dac_verbs instance; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module dac_verbs_assertions #(
  parameter int PIPE_OF_PIN = 0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire dac_pkg::dac_cmd_s cmd,
  input wire logic vendor_node,
  input wire logic transcoder_port_mode,
  input wire dac_pkg::dac_pipe_s [3:0] pipe_status,
  input wire logic [31:0] wall_clock,
  input wire dac_pkg::dac_rsp_s rsp,
  input wire logic [4:0] unsol_subtag,
  input wire logic [7:0] converter_channel_map,
  input wire logic [31:0] time_code_offset,
  input wire logic multistream_mode
);
  import dac_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  wire logic pin_cmd = cmd.valid && !vendor_node;
  wire logic ven_cmd = cmd.valid && vendor_node;
  wire dac_pipe_s own = pipe_status[PIPE_OF_PIN];
  wire logic [2:0] own_bits = {own.presence_sensed, own.sink_info_valid, own.sink_idle};
  sequence trig_s;
    ven_cmd && cmd.verb == DAC_V_TRIG;
  endsequence
  sequence cwc_s;
    ven_cmd && cmd.verb == DAC_V_CAPTURED_WALL_CLOCK;
  endsequence
  // ==========================================================================
  // Assertions.
  answer_pulse_a: assert property (cmd.valid |=> rsp.valid) else $error("verb not answered");
  idle_quiet_a: assert property (!cmd.valid |=> !rsp.valid) else $error("answer without verb");
  set_zero_a: assert property (cmd.valid && !cmd.verb[11] |=> rsp.data == 32'h0)
    else $error("set verb answered nonzero");
  caps_type_a: assert property (
    ven_cmd && cmd.verb == DAC_V_GET_PARAM && cmd.payload == DAC_PARAM_AWC
    |=> rsp.data == 32'h00F0_0000) else $error("vendor caps word wrong");
  single_sense_a: assert property (
    pin_cmd && cmd.verb == DAC_V_PIN_SENSE && !transcoder_port_mode
    |=> rsp.data == {$past(own_bits), 29'h0}) else $error("pin sense word wrong");
  stream_mode_a: assert property (!transcoder_port_mode |=> !multistream_mode)
    else $error("multistream without transcoder mode");
  subtag_store_a: assert property (
    pin_cmd && cmd.verb == DAC_V_SET_PROT |=> unsol_subtag == $past(cmd.payload[7:3]))
    else $error("subtag not stored");
  chan_map_a: assert property (
    pin_cmd && cmd.verb == DAC_V_SET_CCMAP |=> converter_channel_map == $past(cmd.payload))
    else $error("channel map not stored");
  offset_top_a: assert property (
    ven_cmd && cmd.verb == DAC_V_SET_OFS3
    |=> time_code_offset[31:24] == $past(cmd.payload) && $stable(time_code_offset[23:0]))
    else $error("offset top byte wrong");
  wall_capture_a: assert property (
    trig_s ##2 cwc_s |=> rsp.data == $past(wall_clock, 3)) else $error("wall clock capture wrong");
endmodule : dac_verbs_assertions
bind dac_verbs dac_verbs_assertions #(.PIPE_OF_PIN(PIPE_OF_PIN)) u_chk (
  .clk_sys, .resetn, .cmd, .vendor_node, .transcoder_port_mode, .pipe_status,
  .wall_clock, .rsp, .unsol_subtag, .converter_channel_map, .time_code_offset,
  .multistream_mode
);
`default_nettype wire

// ==== testbench/dac_host.sv ====
// Controller model: issues one verb at a time and collects its answer.
// Drives at the falling edge; holds the verb until the taking edge has passed.
`timescale 1ns/1ns
`default_nettype none
module dac_host (
  input wire logic clk_sys,
  output var dac_pkg::dac_cmd_s cmd,
  output var logic vendor_node,
  input wire dac_pkg::dac_rsp_s rsp,
  input wire logic unsol_event
);
  import dac_pkg::*;
  logic [31:0] data;
  logic evt;
  initial begin
    cmd = '0;
    vendor_node = 1'h0;
  end
  task automatic xfer(input logic vn, input logic [11:0] verb, input logic [7:0] pl);
    @(negedge clk_sys);
    cmd = '{1'h1, verb, pl};
    vendor_node = vn;
    @(negedge clk_sys);
    // The answer stands only for the cycle after the taking edge, so it is taken here.
    data = (rsp.valid === 1'h1) ? rsp.data : 'x;
    evt = unsol_event;
    // Released lines show the inverse so a stale value never passes for a live one.
    cmd = '{1'h0, ~verb, ~pl};
    vendor_node = ~vn;
    // One more edge lets the outputs that lag the verb by a cycle settle.
    @(posedge clk_sys);
    #1;
  endtask : xfer
endmodule : dac_host
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for dac_verbs: verb sequences with expected answers.
// Uses dac_host for the verb handshake; the checker arrives by bind.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dac_pkg::*;
  localparam logic PIN = 1'h0;
  localparam logic VEN = 1'h1;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic transcoder_port_mode = 1'h0;
  dac_pipe_s [3:0] pipe_status = '0;
  logic [31:0] global_time_code = 32'h0;
  logic [31:0] wall_clock = 32'h0;
  dac_cmd_s cmd;
  logic vendor_node;
  dac_rsp_s rsp;
  logic unsol_event;
  logic [5:0] unsol_label;
  logic [4:0] unsol_subtag;
  logic [1:0] infoframe_send_policy;
  logic [2:0] infoframe_slot;
  logic [7:0] converter_channel_map;
  logic [7:0] stream_id_tag;
  logic [31:0] time_code_offset;
  logic [5:0] time_code_device_index;
  logic multistream_mode;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  dac_verbs uut (.clk_sys, .resetn, .cmd, .vendor_node, .transcoder_port_mode, .pipe_status,
    .global_time_code, .wall_clock, .rsp, .unsol_event, .unsol_label, .unsol_subtag,
    .infoframe_send_policy, .infoframe_slot, .converter_channel_map, .stream_id_tag,
    .time_code_offset, .time_code_device_index, .multistream_mode);
  dac_host u_host (.clk_sys, .cmd, .vendor_node, .rsp, .unsol_event);
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic vn, input logic [11:0] v, input logic [7:0] p,
    input logic [31:0] exp);
    u_host.xfer(vn, v, p);
    chk(u_host.data, exp);
  endtask : rd
  task automatic wr(input logic vn, input logic [11:0] v, input logic [7:0] p);
    rd(vn, v, p, 32'h0);
  endtask : wr
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(negedge clk_sys);
    resetn = 1'h1;
    rd(PIN, DAC_V_GET_IFIDX, 8'h00, 32'h0);
    rd(PIN, DAC_V_GET_IFTX, 8'h00, 32'h0);
    rd(PIN, DAC_V_GET_CCMAP, 8'h00, 32'h0);
    rd(VEN, DAC_V_GET_OFS, 8'h00, 32'h0);
    rd(VEN, DAC_V_CAPTURED_WALL_CLOCK, 8'h00, 32'h0);
    rd(VEN, DAC_V_GET_CGTC, 8'h00, 32'h0);
    rd(PIN, 12'hF99, 8'h00, 32'h0);
    done("reset");
    wr(PIN, DAC_V_SET_CFG0, 8'h21);
    wr(PIN, DAC_V_SET_CFG1, 8'h43);
    wr(PIN, DAC_V_SET_CFG2, 8'h65);
    for (int k = 0; k < 4; k++) begin
      wr(PIN, DAC_V_SET_CFG3, {k[1:0], 6'h07});
      rd(PIN, DAC_V_GET_CFG, 8'h00, {k[1:0], 30'h0765_4321});
    end
    wr(VEN, DAC_V_SET_UNSOL, 8'h95);
    chk(32'(unsol_label), 32'h15);
    wr(VEN, DAC_V_SET_CFG2, 8'h5A);
    chk(32'(u_host.evt), 32'h1);
    wr(VEN, DAC_V_SET_UNSOL, 8'h15);
    wr(VEN, DAC_V_SET_CFG2, 8'h3C);
    chk(32'(u_host.evt), 32'h0);
    rd(VEN, DAC_V_GET_MBOX, 8'h00, 32'hC73C_4321);
    rd(VEN, DAC_V_GET_PARAM, DAC_PARAM_AWC, 32'h00F0_0000);
    done("config");
    wr(PIN, DAC_V_SET_IFIDX, 8'h23);
    chk(32'(infoframe_slot), 32'h1);
    wr(PIN, DAC_V_SET_IFDATA, 8'hAA);
    wr(PIN, DAC_V_SET_IFDATA, 8'hBB);
    rd(PIN, DAC_V_GET_IFIDX, 8'h00, 32'h25);
    wr(PIN, DAC_V_SET_IFIDX, 8'h23);
    rd(PIN, DAC_V_GET_IFDATA, 8'h00, 32'hAA);
    rd(PIN, DAC_V_GET_IFDATA, 8'h00, 32'hBB);
    wr(PIN, DAC_V_SET_IFIDX, 8'hA0);
    wr(PIN, DAC_V_SET_IFDATA, 8'h11);
    rd(PIN, DAC_V_GET_IFDATA, 8'h00, 32'h0);
    wr(PIN, DAC_V_SET_IFIDX, 8'h20);
    for (int p = 0; p < 4; p++) begin
      if (p == 1) continue;
      wr(PIN, DAC_V_SET_IFTX, {p[1:0], 6'h00});
      rd(PIN, DAC_V_GET_IFTX, 8'h00, {24'h0, p[1:0], 6'h00});
      chk(32'(infoframe_send_policy), 32'(p));
    end
    for (int i = 0; i < 9; i++) begin
      rd(PIN, DAC_V_IF_SIZE, 8'(i), i < 4 ? 32'h1E : (i == 8 ? 32'h53 : 32'h0));
    end
    done("infoframe");
    wr(PIN, DAC_V_SET_PROT, 8'hF8);
    chk(32'(unsol_subtag), 32'h1F);
    wr(PIN, DAC_V_SET_CCMAP, 8'hA5);
    rd(PIN, DAC_V_GET_CCMAP, 8'h00, 32'hA5);
    wr(PIN, DAC_V_SET_SSID, 8'h9A);
    rd(PIN, DAC_V_GET_SSID, 8'h00, 32'h9A);
    chk(32'(stream_id_tag), 32'h9A);
    pipe_status = 12'h573;
    rd(PIN, DAC_V_PIN_SENSE, 8'h02, 32'hC000_0000);
    transcoder_port_mode = 1'h1;
    rd(PIN, DAC_V_PIN_SENSE, 8'h02, 32'hC000_0000);
    wr(VEN, DAC_V_SET_VEND, 8'h02);
    chk(32'(multistream_mode), 32'h1);
    rd(PIN, DAC_V_PIN_SENSE, 8'h02, 32'hA000_0000);
    rd(PIN, DAC_V_PIN_SENSE, 8'h05, 32'h0);
    rd(PIN, DAC_V_GET_DDL, 8'h00, 32'h2563);
    wr(PIN, DAC_V_SET_DEVSEL, 8'h02);
    rd(PIN, DAC_V_GET_DEVSEL, 8'h00, 32'h82);
    wr(VEN, DAC_V_SET_VEND, 8'h00);
    rd(PIN, DAC_V_GET_DEVSEL, 8'h00, 32'h02);
    transcoder_port_mode = 1'h0;
    done("sense");
    wall_clock = 32'h1234_5678;
    global_time_code = 32'h9ABC_DEF0;
    wr(VEN, DAC_V_TRIG, 8'h5C);
    wall_clock = 32'h0F0F_0F0F;
    global_time_code = 32'hF0F0_F0F0;
    rd(VEN, DAC_V_CAPTURED_WALL_CLOCK, 8'h00, 32'h1234_5678);
    rd(VEN, DAC_V_GET_CGTC, 8'h00, 32'h9ABC_DEF0);
    for (int b = 0; b < 4; b++) begin
      wr(VEN, DAC_V_SET_OFS0 + 12'(b), 8'h10 + 8'(b));
    end
    rd(VEN, DAC_V_GET_OFS, 8'h00, 32'h1312_1110);
    chk(time_code_offset, 32'h1312_1110);
    wr(VEN, DAC_V_SET_GDI, 8'h03);
    rd(VEN, DAC_V_GET_GDI, 8'h00, 32'h03);
    chk(32'(time_code_device_index), 32'h03);
    done("time code");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
